// [bench/cta_cpu.sv]
// processor side model issuing one-cycle byte strobes
`timescale 1ns/10ps
module cta_cpu (
  input  wire logic        clk,
  input  wire logic [7:0]  bus_rdata,
  output logic      [15:0] bus_addr,
  output logic      [7:0]  bus_wdata,
  output logic             bus_wr,
  output logic             bus_rd
);
  import cta_pkg::*;
  // quiet bus at time zero
  initial begin
    bus_addr  = CTA_ADDR_CNT_LO;
    bus_wdata = CTA_RST_RDATA;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
  end
  ////////////////////////////////////////
  // one bus cycle; callers always start at a rising edge
  task automatic acc(logic w, logic r, logic [15:0] a, logic [7:0] dat);
    bus_wr    <= w;
    bus_rd    <= r;
    bus_addr  <= a;
    bus_wdata <= dat;
    @(posedge clk);
  endtask
  // released data flips every cycle so a stale byte never passes for fresh
  task automatic idle();
    acc(1'b0, 1'b0, bus_addr, ~bus_wdata);
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] dat);
    acc(1'b1, 1'b0, a, dat);
  endtask
  // the answer is taken one edge after the strobe edge
  task automatic rd(logic [15:0] a, output logic [7:0] dat);
    acc(1'b0, 1'b1, a, ~bus_wdata);
    idle();
    dat = bus_rdata;
  endtask
endmodule

// [bench/cta_timer_checker.sv]
// assertions on the counter a timer pins
`timescale 1ns/10ps
module cta_timer_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic        mode_select_low_bit,
  input wire logic        mode_select_high_bit,
  input wire logic        timer_underflow_irq_enable,
  input wire logic        serial_internal_clk_en,
  input wire logic        gpio_bit_four_out,
  input wire logic        gpio_bit_four_oe,
  input wire logic        port_a_bit_four_i,
  input wire logic        port_a_bit_four_o,
  input wire logic        port_a_bit_four_oe,
  input wire logic        port_a_bit_four_level,
  input wire logic        timer_underflow_flag,
  input wire logic        timer_irq,
  input wire logic        serial_bit_clk_en
);
  import cta_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic gp;
  logic pm;
  logic ld;
  // gpio use, pulse mode and load strobe; serial enable overrides the mode bits
  assign gp = serial_internal_clk_en | ~(mode_select_high_bit | mode_select_low_bit);
  assign pm = ~serial_internal_clk_en & ~mode_select_high_bit & mode_select_low_bit;
  assign ld = bus_wr & (bus_addr == CTA_ADDR_LOAD);
  ////////////////////////////////////////
  chk_irq_gate:
    assert property ($past(nrst) |-> timer_irq == (timer_underflow_flag & $past(timer_underflow_irq_enable)))
    else $error("irq differs from flag and enable");
  chk_load_clear:
    assert property (ld |=> !timer_underflow_flag) else $error("load left flag set");
  chk_flag_fall:
    assert property ($fell(timer_underflow_flag) |-> $past(ld | (bus_rd & ~bus_wr & bus_addr == CTA_ADDR_CNT_LO)))
    else $error("flag cleared without cause");
  chk_gpio_pass:
    assert property ($past(nrst & gp) |-> port_a_bit_four_oe == $past(gpio_bit_four_oe)
      && port_a_bit_four_o == $past(gpio_bit_four_out)) else $error("port bit not passed through");
  chk_line_free:
    assert property ($past(nrst & ~gp & mode_select_high_bit) |-> !port_a_bit_four_oe)
    else $error("input line driven");
  chk_pulse_drv:
    assert property ($past(nrst & pm) |-> port_a_bit_four_oe) else $error("pulse line not driven");
  chk_pulse_entry:
    assert property ($rose(pm) |=> port_a_bit_four_o) else $error("pulse entry not high");
  chk_pulse_tog:
    assert property (pm && $past(pm) && ld |=> port_a_bit_four_o != $past(port_a_bit_four_o))
    else $error("load did not toggle pulse line");
  chk_level_hi:
    assert property (port_a_bit_four_i [*6] |-> port_a_bit_four_level) else $error("level not high");
  chk_level_lo:
    assert property (!port_a_bit_four_i [*6] |-> !port_a_bit_four_level) else $error("level not low");
  chk_bit_gap:
    assert property (serial_bit_clk_en |=> !serial_bit_clk_en [*8]) else $error("bit clock too close");
endmodule
bind cta_timer cta_timer_checker chk (.*);

// [bench/tb.sv]
// self-checking bench for the counter a timer
`timescale 1ns/10ps
module tb;
  import cta_pkg::*;
  typedef struct {logic [1:0] m; logic p; logic [15:0] v, a; int g; logic [7:0] e;} cta_row_t;
  logic        clk, nrst, bus_wr, bus_rd, mode_select_low_bit, mode_select_high_bit;
  logic        timer_underflow_irq_enable, serial_internal_clk_en, gpio_bit_four_out;
  logic        gpio_bit_four_oe, port_a_bit_four_i, port_a_bit_four_o, port_a_bit_four_oe;
  logic        port_a_bit_four_level, timer_underflow_flag, timer_irq, serial_bit_clk_en;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, d;
  int          n_errors, compares, cyc, i;
  // mode, pin, load value, read location, idle cycles before the read, byte expected
  cta_row_t rows [8] = '{
    '{CTA_MODE_INTERVAL, 1'b1, 16'h1234, CTA_ADDR_CNT_HI, 0, 8'h12},
    '{CTA_MODE_INTERVAL, 1'b1, 16'h1234, CTA_ADDR_CNT_LO, 0, 8'h34},
    '{CTA_MODE_INTERVAL, 1'b1, 16'h1234, CTA_ADDR_LOAD, 5, 8'h2f},
    '{CTA_MODE_INTERVAL, 1'b1, 16'h0100, CTA_ADDR_CNT_HI, 1, 8'h00},
    '{CTA_MODE_EVENT, 1'b1, 16'h5678, CTA_ADDR_CNT_LO, 7, 8'h78},
    '{CTA_MODE_WIDTH, 1'b1, 16'h9abc, CTA_ADDR_CNT_LO, 7, 8'hbc},
    '{CTA_MODE_WIDTH, 1'b0, 16'h9abc, CTA_ADDR_CNT_LO, 7, 8'hb5},
    '{CTA_MODE_INTERVAL, 1'b1, 16'h1234, 16'h0017, 0, CTA_UNMAPPED}};
  cta_timer uut (.*);
  cta_cpu   cpu (.*);
  ////////////////////////////////////////
  // clock, and a cycle ceiling well above the few hundred cycles the run needs
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk8(string n, logic [7:0] e, logic [7:0] s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk1(string n, logic e, logic s);
    chk8(n, {7'h00, e}, {7'h00, s});
  endtask
  task automatic tick(int k);
    repeat (k) cpu.idle();
  endtask
  task automatic load(logic [15:0] v);
    cpu.wr(CTA_ADDR_CNT_LO, v[7:0]);
    cpu.wr(CTA_ADDR_LOAD, v[15:8]);
  endtask
  task automatic finish_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    {nrst, mode_select_high_bit, mode_select_low_bit, timer_underflow_irq_enable} = 4'h0;
    {serial_internal_clk_en, gpio_bit_four_out, gpio_bit_four_oe, port_a_bit_four_i} = 4'h1;
    repeat (12) @(posedge clk);
    chk8("rdata", CTA_RST_RDATA, bus_rdata);
    chk1("flag", 1'b0, timer_underflow_flag);
    chk1("oe", 1'b0, port_a_bit_four_oe);
    nrst <= 1'b1;
    foreach (rows[k]) begin
      {mode_select_high_bit, mode_select_low_bit} <= rows[k].m;
      port_a_bit_four_i <= rows[k].p;
      tick(6);
      load(rows[k].v);
      tick(rows[k].g);
      cpu.rd(rows[k].a, d);
      chk8("count byte", rows[k].e, d);
    end
    // underflow, reload from the latch, flag and request
    timer_underflow_irq_enable <= 1'b1;
    load(16'h0003);
    tick(4);
    chk1("flag", 1'b0, timer_underflow_flag);
    tick(1);
    chk1("flag", 1'b1, timer_underflow_flag);
    chk1("irq", 1'b1, timer_irq);
    cpu.wr(CTA_ADDR_CNT_LO, 8'hff);
    cpu.wr(CTA_ADDR_CNT_HI, 8'h7f);
    tick(4);
    cpu.rd(CTA_ADDR_CNT_HI, d);
    chk8("count hi", 8'h7f, d);
    cpu.rd(CTA_ADDR_CNT_LO, d);
    chk1("flag", 1'b0, timer_underflow_flag);
    chk1("irq", 1'b0, timer_irq);
    timer_underflow_irq_enable <= 1'b0;
    load(16'h0001);
    tick(4);
    chk1("flag", 1'b1, timer_underflow_flag);
    chk1("irq", 1'b0, timer_irq);
    cpu.wr(CTA_ADDR_LOAD, 8'h00);
    tick(1);
    chk1("flag", 1'b0, timer_underflow_flag);
    // pulse line: high on entry, low on load, back high on underflow
    load(16'h4000);
    {mode_select_high_bit, mode_select_low_bit} <= CTA_MODE_PULSE;
    tick(3);
    chk1("pulse oe", 1'b1, port_a_bit_four_oe);
    chk1("pulse out", 1'b1, port_a_bit_four_o);
    load(16'h0004);
    tick(2);
    chk1("pulse out", 1'b0, port_a_bit_four_o);
    tick(3);
    chk1("pulse out", 1'b0, port_a_bit_four_o);
    tick(1);
    chk1("pulse out", 1'b1, port_a_bit_four_o);
    // three rising edges, spaced wider than the fastest allowed source
    {mode_select_high_bit, mode_select_low_bit} <= CTA_MODE_EVENT;
    load(16'h0010);
    for (int k = 0; k < 3; k++) begin
      port_a_bit_four_i <= 1'b0;
      tick(3);
      port_a_bit_four_i <= 1'b1;
      tick(3);
    end
    tick(6);
    cpu.rd(CTA_ADDR_CNT_LO, d);
    chk8("event count", 8'h0d, d);
    // port bit ownership per mode
    {mode_select_high_bit, mode_select_low_bit} <= CTA_MODE_INTERVAL;
    gpio_bit_four_out <= 1'b0;
    gpio_bit_four_oe <= 1'b1;
    tick(3);
    chk1("gpio oe", 1'b1, port_a_bit_four_oe);
    chk1("gpio out", 1'b0, port_a_bit_four_o);
    {mode_select_high_bit, mode_select_low_bit} <= CTA_MODE_WIDTH;
    serial_internal_clk_en <= 1'b1;
    tick(3);
    chk1("serial oe", 1'b1, port_a_bit_four_oe);
    serial_internal_clk_en <= 1'b0;
    port_a_bit_four_i <= 1'b0;
    tick(6);
    chk1("width oe", 1'b0, port_a_bit_four_oe);
    chk1("level", 1'b0, port_a_bit_four_level);
    // zero latch underflows every cycle, so the bit clock spacing is the divider
    {mode_select_high_bit, mode_select_low_bit} <= CTA_MODE_INTERVAL;
    load(16'h0000);
    i = 0;
    while (serial_bit_clk_en !== 1'b1 && i < 40) begin
      tick(1);
      i++;
    end
    i = 0;
    do begin
      tick(1);
      i++;
    end while (serial_bit_clk_en !== 1'b1 && i < 40);
    chk8("bit gap", 8'(CTA_BIT_DIV), 8'(i));
    // reset in mid-run while the flag is set
    nrst <= 1'b0;
    tick(2);
    chk1("flag", 1'b0, timer_underflow_flag);
    nrst <= 1'b1;
    tick(2);
    finish_test();
  end
endmodule

// [src/cta_div.sv]
// divides counter underflows by sixteen into the serial bit clock enable
`timescale 1ns/10ps
module cta_div (
  input  wire logic clk,
  input  wire logic nrst,
  cta_line_if.div   line
);
  import cta_pkg::*;

  typedef struct packed {
    logic [CTA_BIT_DIV_W-1:0] cnt;
    logic                     tick;
  } cta_div_st_t;

  cta_div_st_t st_q;
  cta_div_st_t st_d;

  // one bit clock per sixteen underflows
  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (line.uf_tick) begin
      if (st_q.cnt == CTA_BIT_LAST) begin
        st_d.cnt  = CTA_BIT_ZERO;
        st_d.tick = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + CTA_BIT_STEP;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign line.bit_tick = st_q.tick;
endmodule

// [src/cta_line_if.sv]
// carrier between the counter core, the pin synchroniser and the bit divider
`timescale 1ns/10ps
interface cta_line_if;
  logic raw;      // counter line as it arrives from the pin
  logic level;    // filtered level of the line
  logic rise;     // one-cycle pulse on a rising edge
  logic uf_tick;  // one-cycle pulse per counter underflow
  logic bit_tick; // one-cycle pulse, serial bit clock

  modport sync (input raw, output level, output rise);
  modport div  (input uf_tick, output bit_tick);
  modport core (output raw, input level, input rise,
                output uf_tick, input bit_tick);
endinterface

// [src/cta_pkg.sv]
// constants and encodings shared by the counter a timer files
package cta_pkg;

  // processor byte locations of the counter
  localparam logic [15:0] CTA_ADDR_CNT_LO = 16'h0018;
  localparam logic [15:0] CTA_ADDR_CNT_HI = 16'h0019;
  localparam logic [15:0] CTA_ADDR_LOAD   = 16'h001a;

  // mode select encodings, high bit then low bit
  localparam logic [1:0] CTA_MODE_INTERVAL = 2'h0;
  localparam logic [1:0] CTA_MODE_PULSE    = 2'h1;
  localparam logic [1:0] CTA_MODE_EVENT    = 2'h2;
  localparam logic [1:0] CTA_MODE_WIDTH    = 2'h3;

  // field positions of the 16-bit count and latch
  localparam int CTA_LO_MSB = 7;
  localparam int CTA_HI_LSB = 8;
  localparam int CTA_HI_MSB = 15;

  // reset values, unmapped read byte and count constants
  localparam logic [15:0] CTA_RST_COUNT = 16'h0000;
  localparam logic [15:0] CTA_RST_LATCH = 16'h0000;
  localparam logic [7:0]  CTA_RST_RDATA = 8'h00;
  localparam logic [7:0]  CTA_UNMAPPED  = 8'h00;
  localparam logic        CTA_RST_PIN   = 1'b1;
  localparam logic [15:0] CTA_ZERO      = 16'h0000;
  localparam logic [15:0] CTA_ONE       = 16'h0001;

  // timing: clock and serial bit clock division
  localparam int CTA_CLK_PERIOD_NS = 100;
  localparam int CTA_BIT_DIV       = 16;
  localparam int CTA_BIT_DIV_W     = $clog2(CTA_BIT_DIV);
  localparam logic [CTA_BIT_DIV_W-1:0] CTA_BIT_LAST =
    CTA_BIT_DIV_W'(CTA_BIT_DIV - 1);
  localparam logic [CTA_BIT_DIV_W-1:0] CTA_BIT_ZERO = '0;
  localparam logic [CTA_BIT_DIV_W-1:0] CTA_BIT_STEP =
    CTA_BIT_DIV_W'(1);
  // event edges may come at most every second clock
  localparam int CTA_EVT_MIN_CYC = 2;

endpackage

// [src/cta_sync.sv]
// three-stage synchroniser of the counter line with level and rise outputs
`timescale 1ns/10ps
module cta_sync (
  input  wire logic clk,
  input  wire logic nrst,
  cta_line_if.sync  line
);
  import cta_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } cta_sync_st_t;

  cta_sync_st_t st_q;
  cta_sync_st_t st_d;

  // s1 only feeds s2; a change counts once s2 and s3 agree
  always_comb begin
    st_d       = st_q;
    st_d.s1    = line.raw;
    st_d.s2    = st_q.s1;
    st_d.s3    = st_q.s2;
    st_d.rise  = 1'b0;
    if (st_q.s2 == st_q.s3) begin
      st_d.level = st_q.s3;
      st_d.rise  = st_q.s3 & ~st_q.level;
    end
  end

  // pin idles high, so reset to high avoids a false first edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= {CTA_RST_PIN, CTA_RST_PIN, CTA_RST_PIN, CTA_RST_PIN, 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign line.level = st_q.level;
  assign line.rise  = st_q.rise;
endmodule

// [src/cta_timer.sv]
// counter a: 16-bit down-counter with reload latch, four modes and bit clock
`timescale 1ns/10ps
module cta_timer (
  input  wire logic                clk,
  input  wire logic                nrst,
  // processor byte access
  input  wire logic [15:0]         bus_addr,
  input  wire logic [7:0]          bus_wdata,
  input  wire logic                bus_wr,
  input  wire logic                bus_rd,
  output logic      [7:0]          bus_rdata,
  // control bits held in the device control registers
  input  wire logic                mode_select_low_bit,
  input  wire logic                mode_select_high_bit,
  input  wire logic                timer_underflow_irq_enable,
  input  wire logic                serial_internal_clk_en,
  // ordinary port logic for port a bit four
  input  wire logic                gpio_bit_four_out,
  input  wire logic                gpio_bit_four_oe,
  // port a bit four pin
  input  wire logic                port_a_bit_four_i,
  output logic                     port_a_bit_four_o,
  output logic                     port_a_bit_four_oe,
  output logic                     port_a_bit_four_level,
  // status and serial timing
  output logic                     timer_underflow_flag,
  output logic                     timer_irq,
  output logic                     serial_bit_clk_en
);
  import cta_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // usage and timing notes
  //
  // bus side
  //   a write is taken at the rising edge that sees bus_wr high; the latch
  //   byte is in place from that edge, and a load write restarts the count
  //   at that same edge
  //   a read is taken at the edge that sees bus_rd high; bus_rdata shows the
  //   count as it stood in the strobe cycle from that same edge and holds it
  //   until the next read; there is no snapshot, so reading the upper byte
  //   and then the lower byte can tear across a borrow
  //   every high cycle of a strobe is a separate access, side effects too
  //
  // counting
  //   a latch value n gives an underflow every n plus one counted cycles, so
  //   a zero latch underflows on every count enable
  //   a load write wins over the decrement of its own cycle, so the flag is
  //   never set and cleared by the same load
  //   an underflow that meets a clearing read keeps the flag set; software
  //   that polls the flag loses no event this way
  //
  // counter line
  //   the pin reaches the level output five edges after it changes: three
  //   synchroniser stages, the agreement stage and the output register
  //   a rising edge decrements the count one edge after the agreement stage,
  //   so event pulses must stay at least two clocks in each level; one-clock
  //   pulses are filtered away
  //   in pulse mode the pin follows the internal pulse bit with no extra
  //   register, so the line changes at the edge of the toggling event
  //
  // serial timing
  //   the bit clock enable is one pulse per sixteen underflows in every mode;
  //   the serial enable forces interval counting so the rate never depends
  //   on the pin
  //   the pin itself is left to the port logic while the serial enable is
  //   high; any serial use of it lives outside this block
  //
  // reset
  //   count and latch clear to zero, so an interval timer left alone after
  //   reset underflows on every clock and sets the flag at the first edge;
  //   software loads the latch before enabling the request
  //   the pin is released high and the mode history reads as interval, so
  //   selecting pulse mode right after reset still raises the line
  //
  // limits
  //   the event input is sampled, not clocked by the pin, so its rate is
  //   bounded by the clock; sources faster than a quarter of the clock lose edges
  //   a mode change takes effect at the next edge with no handshake; a count
  //   in flight keeps its value across the change

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] latch;
    logic        flag;
    logic        irq;
    logic [7:0]  rdata;
    logic [1:0]  mode_prev;
    logic        pulse;
    logic        pin_o;
    logic        pin_oe;
    logic        level;
    logic        uf;
  } cta_core_st_t;

  cta_core_st_t st_q;
  cta_core_st_t st_d;

  cta_line_if line ();

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // exact match of a full 16-bit location, used by read and write decode
  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] loc);
    hit = (a == loc);
  endfunction

  // byte lane of a 16-bit word; shared by every read location
  function automatic logic [7:0] byte_of(input logic [15:0] w,
                                         input logic        upper);
    if (upper) begin
      byte_of = w[CTA_HI_MSB:CTA_HI_LSB];
    end else begin
      byte_of = w[CTA_LO_MSB:0];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // submodules

  // pin synchroniser: raw line in, filtered level and edge out
  cta_sync u_sync (
    .clk  (clk),
    .nrst (nrst),
    .line (line.sync)
  );

  // bit clock divider fed by the registered underflow pulse
  cta_div u_div (
    .clk  (clk),
    .nrst (nrst),
    .line (line.div)
  );

  assign line.raw     = port_a_bit_four_i;
  assign line.uf_tick = st_q.uf;

  //////////////////////////////////////////////////////////////////////////////
  // decode

  logic [1:0] mode;
  logic       wr_lo;
  logic       wr_hi;
  logic       wr_load;
  logic       rd_lo;
  logic       rd_hi;
  logic       rd_alt;
  logic       dec_en;
  logic       at_zero;
  logic       enter_pulse;

  // serial use of the counter overrides the selected mode
  always_comb begin
    if (serial_internal_clk_en) begin
      mode = CTA_MODE_INTERVAL;
    end else begin
      mode = {mode_select_high_bit, mode_select_low_bit};
    end
  end

  // address strobes; a write and a read never share a cycle
  always_comb begin
    wr_lo   = 1'b0;
    wr_hi   = 1'b0;
    wr_load = 1'b0;
    rd_lo   = 1'b0;
    rd_hi   = 1'b0;
    rd_alt  = 1'b0;
    if (bus_wr && hit(bus_addr, CTA_ADDR_CNT_LO)) begin
      wr_lo = 1'b1;
    end else if (bus_wr && hit(bus_addr, CTA_ADDR_CNT_HI)) begin
      wr_hi = 1'b1;
    end else if (bus_wr && hit(bus_addr, CTA_ADDR_LOAD)) begin
      wr_load = 1'b1;
    end else if (bus_rd && hit(bus_addr, CTA_ADDR_CNT_LO)) begin
      rd_lo = 1'b1;
    end else if (bus_rd && hit(bus_addr, CTA_ADDR_CNT_HI)) begin
      rd_hi = 1'b1;
    end else if (bus_rd && hit(bus_addr, CTA_ADDR_LOAD)) begin
      rd_alt = 1'b1;
    end
  end

  // count source per mode
  always_comb begin
    case (mode)
      CTA_MODE_INTERVAL: begin
        dec_en = 1'b1;
      end
      CTA_MODE_PULSE: begin
        dec_en = 1'b1;
      end
      CTA_MODE_EVENT: begin
        dec_en = line.rise;
      end
      default: begin
        // low level counts, high level holds the present value
        dec_en = ~line.level;
      end
    endcase
  end

  assign at_zero     = (st_q.count == CTA_ZERO);
  assign enter_pulse = (mode == CTA_MODE_PULSE) &&
                       (st_q.mode_prev != CTA_MODE_PULSE);

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d           = st_q;
    st_d.uf        = 1'b0;
    st_d.mode_prev = mode;
    st_d.level     = line.level;

    // latch bytes; of these only the load write also touches the running count
    if (wr_lo) begin
      st_d.latch[CTA_LO_MSB:0] = bus_wdata;
    end
    if (wr_hi || wr_load) begin
      st_d.latch[CTA_HI_MSB:CTA_HI_LSB] = bus_wdata;
    end

    // counter: a load beats a decrement in the same cycle
    if (wr_load) begin
      st_d.count = {bus_wdata, st_q.latch[CTA_LO_MSB:0]};
    end else if (dec_en) begin
      if (at_zero) begin
        st_d.count = st_q.latch;
        st_d.uf    = 1'b1;
      end else begin
        st_d.count = st_q.count - CTA_ONE;
      end
    end

    // flag: an underflow in the clearing cycle still sets it
    if (st_d.uf) begin
      st_d.flag = 1'b1;
    end else if (rd_lo || wr_load) begin
      st_d.flag = 1'b0;
    end

    st_d.irq = st_d.flag & timer_underflow_irq_enable;

    // pulse output: set high on entry, toggled by underflow or load
    if (enter_pulse) begin
      st_d.pulse = 1'b1;
    end else if (wr_load ^ st_d.uf) begin
      st_d.pulse = ~st_q.pulse;
    end

    // pin ownership follows the mode
    case (mode)
      CTA_MODE_INTERVAL: begin
        st_d.pin_o  = gpio_bit_four_out;
        st_d.pin_oe = gpio_bit_four_oe;
      end
      CTA_MODE_PULSE: begin
        st_d.pin_o  = st_d.pulse;
        st_d.pin_oe = 1'b1;
      end
      default: begin
        // counter input: released so the outside drives the line
        st_d.pin_o  = CTA_RST_PIN;
        st_d.pin_oe = 1'b0;
      end
    endcase

    // read data: answer one cycle after the strobe, no snapshot
    if (rd_lo || rd_alt) begin
      st_d.rdata = byte_of(st_q.count, 1'b0);
    end else if (rd_hi) begin
      st_d.rdata = byte_of(st_q.count, 1'b1);
    end else if (bus_rd) begin
      st_d.rdata = CTA_UNMAPPED;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  // reset clears flag and leaves the pin released high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q.count     <= CTA_RST_COUNT;
      st_q.latch     <= CTA_RST_LATCH;
      st_q.flag      <= 1'b0;
      st_q.irq       <= 1'b0;
      st_q.rdata     <= CTA_RST_RDATA;
      st_q.mode_prev <= CTA_MODE_INTERVAL;
      st_q.pulse     <= CTA_RST_PIN;
      st_q.pin_o     <= CTA_RST_PIN;
      st_q.pin_oe    <= 1'b0;
      st_q.level     <= CTA_RST_PIN;
      st_q.uf        <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign bus_rdata             = st_q.rdata;
  assign port_a_bit_four_o     = st_q.pin_o;
  assign port_a_bit_four_oe    = st_q.pin_oe;
  assign port_a_bit_four_level = st_q.level;
  assign timer_underflow_flag  = st_q.flag;
  assign timer_irq             = st_q.irq;
  assign serial_bit_clk_en     = line.bit_tick;

endmodule
